// [verilog/spc_regs.vh]
// Purpose: Constants for the serial parameter channel command interpreter.
// Assumes: 16-bit words, identifier/index/value words arrive already framed and checked.
// Notes: Offsets are word indices on the plain register port; byte address is index times two.
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
`define SPC_ADR_IDENT 4'h0
`define SPC_ADR_INDEX 4'h1
`define SPC_ADR_VAL_HI 4'h2
`define SPC_ADR_VAL_LO 4'h3
`define SPC_ADR_GO 4'h4
`define SPC_ADR_R_IDENT 4'h5
`define SPC_ADR_R_INDEX 4'h6
`define SPC_ADR_R_VAL_HI 4'h7
`define SPC_ADR_R_VAL_LO 4'h8
`define SPC_ADR_STATUS 4'h9
`define SPC_ADR_IRQ_MASK 4'hA
`define SPC_ADR_CTRL 4'hB
`define SPC_ADR_TEXT_LEN 4'hC
`define SPC_CMD_MSB 15
`define SPC_CMD_LSB 12
`define SPC_PNU_MSB 10
`define SPC_CMD_NONE 4'h0
`define SPC_CMD_READ 4'h1
`define SPC_CMD_WR_W 4'h2
`define SPC_CMD_WR_D 4'h3
`define SPC_CMD_WRP_D 4'hD
`define SPC_CMD_WRP_W 4'hE
`define SPC_CMD_TEXT 4'hF
`define SPC_RPL_NONE 4'h0
`define SPC_RPL_WORD 4'h1
`define SPC_RPL_DWORD 4'h2
`define SPC_RPL_ERR 4'h7
`define SPC_RPL_TEXT 4'hF
`define SPC_ERR_PNU 8'h00
`define SPC_ERR_NOWR 8'h01
`define SPC_ERR_LIMIT 8'h02
`define SPC_ERR_SUBIDX 8'h03
`define SPC_ERR_NOTARR 8'h04
`define SPC_ERR_TYPE 8'h05
`define SPC_ERR_MODE 8'h11
`define SPC_ERR_NOBUS 8'h82
`define SPC_ERR_FACT 8'h83
`define SPC_DT_I16 3'h3
`define SPC_DT_I32 3'h4
`define SPC_DT_U8 3'h5
`define SPC_DT_U16 3'h6
`define SPC_DT_U32 3'h7
`define SPC_DT_TEXT 4'h9
`define SPC_TEXT_FIXED 8'h0A
`define SPC_IDX_TEXT_WR 8'h01
`define SPC_CTRL_RST 4'h0
`endif

// [verilog/spc_channel.v]
// Purpose: Parameter channel interpreter: decodes a request, reads or writes a parameter table, forms the reply.
// Assumes: Framing, checksum and process words are handled elsewhere; table entries are local flip-flops.
// Notes: One request is handled per write to the go register; the reply is ready two cycles after the write strobe.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_channel #(
   parameter NUM_PARAMS = 8,
   parameter ARRAY_LEN = 4,
   parameter TEXT_LEN = 8'h08
) (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire [3:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [15:0] rdata_out,
   output reg irq_out,
   output reg [7:0] telegram_length_byte_out
);
   // Each table entry: number, data type, limits, flags. Entry 0 is an array, entry 1 a text.
   wire [10:0] tbl_pnu [0:NUM_PARAMS-1];
   wire [3:0] tbl_type [0:NUM_PARAMS-1];
   wire [31:0] tbl_max [0:NUM_PARAMS-1];
   wire [NUM_PARAMS-1:0] tbl_wr_ok;
   wire [NUM_PARAMS-1:0] tbl_bus_ok;
   wire [NUM_PARAMS-1:0] tbl_stop_only;
   wire [NUM_PARAMS-1:0] tbl_is_arr;
   reg [31:0] val_r [0:NUM_PARAMS-1];
   reg [31:0] arr_r [0:ARRAY_LEN-1];
   reg [15:0] ident_r;
   reg [15:0] index_r;
   reg [15:0] val_hi_r;
   reg [15:0] val_lo_r;
   reg [15:0] r_ident_r;
   reg [15:0] r_index_r;
   reg [31:0] r_val_r;
   reg [1:0] status_r;
   reg [1:0] mask_r;
   reg [3:0] ctrl_r;
   reg go_r;
   reg [1:0] status_nxt;
   reg [3:0] cmd;
   reg [10:0] param_number_field;
   reg [7:0] idx;
   reg [31:0] wval;
   reg hit;
   reg [2:0] sel;
   reg [3:0] rcode;
   reg [31:0] rval;
   reg err;
   reg do_wr;
   reg is_wr;
   reg is_dw;
   reg [7:0] len_nxt;
   integer k;
   integer j;
   genvar g;

   // Fixed parameter table: numbers follow entry position, type and limits vary with the entry.
   generate
      for (g = 0; g < NUM_PARAMS; g = g + 1)
      begin : g_tbl
         // A sized copy of the position lets each field be sliced to its own width.
         localparam [31:0] POS = g;
         localparam [31:0] TYPE_CODE = 3 + (g % 5);
         assign tbl_pnu[g] = 11'h064 + POS[10:0];
         assign tbl_type[g] = (g == 1) ? `SPC_DT_TEXT : TYPE_CODE[3:0];
         assign tbl_max[g] = (g % 2 == 0) ? 32'h000003E8 : 32'h0000FFFF;
         assign tbl_wr_ok[g] = (g != 3);
         assign tbl_bus_ok[g] = (g != 5);
         assign tbl_stop_only[g] = (g == 4);
         assign tbl_is_arr[g] = (g == 0);
      end
   endgenerate

   // Request decode and reply formation.
   always @*
   begin
      cmd = ident_r[`SPC_CMD_MSB:`SPC_CMD_LSB];
      param_number_field = ident_r[`SPC_PNU_MSB:0];
      idx = index_r[7:0];
      wval = {val_hi_r, val_lo_r};
      hit = 1'b0;
      sel = 3'h0;
      for (k = 0; k < NUM_PARAMS; k = k + 1)
      begin
         if (tbl_pnu[k] == param_number_field)
         begin
            hit = 1'b1;
            sel = k[2:0];
         end
      end
      is_wr = (cmd == `SPC_CMD_WR_W) || (cmd == `SPC_CMD_WR_D) || (cmd == `SPC_CMD_WRP_W) ||
         (cmd == `SPC_CMD_WRP_D);
      is_dw = (cmd == `SPC_CMD_WR_D) || (cmd == `SPC_CMD_WRP_D);
      err = 1'b0;
      rval = 32'h00000000;
      do_wr = 1'b0;
      len_nxt = 8'h0E;
      rcode = `SPC_RPL_NONE;
      if (cmd == `SPC_CMD_NONE)
      begin
         rcode = `SPC_RPL_NONE;
      end
      else if (!hit)
      begin
         err = 1'b1;
         rval = {24'h000000, `SPC_ERR_PNU};
      end
      else if (!tbl_bus_ok[sel])
      begin
         err = 1'b1;
         rval = {24'h000000, `SPC_ERR_NOBUS};
      end
      else if (cmd == `SPC_CMD_TEXT)
      begin
         // Text only on the type-9 entry; index low byte picks read or write.
         if (tbl_type[sel] != `SPC_DT_TEXT)
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_TYPE};
         end
         else if (idx == `SPC_IDX_TEXT_WR && !tbl_wr_ok[sel])
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_NOWR};
         end
         else
         begin
            rcode = `SPC_RPL_TEXT;
            rval = val_r[sel];
            do_wr = (idx == `SPC_IDX_TEXT_WR);
            len_nxt = `SPC_TEXT_FIXED + TEXT_LEN;
         end
      end
      else if (idx != 8'h00 && !tbl_is_arr[sel])
      begin
         err = 1'b1;
         rval = {24'h000000, `SPC_ERR_NOTARR};
      end
      else if (tbl_is_arr[sel] && idx >= ARRAY_LEN)
      begin
         err = 1'b1;
         rval = {24'h000000, `SPC_ERR_SUBIDX};
      end
      else if (cmd == `SPC_CMD_READ)
      begin
         rval = tbl_is_arr[sel] ? arr_r[idx[1:0]] : val_r[sel];
         rcode = (tbl_type[sel] == {1'b0, `SPC_DT_I32} || tbl_type[sel] == {1'b0, `SPC_DT_U32}) ?
            `SPC_RPL_DWORD : `SPC_RPL_WORD;
      end
      else if (is_wr)
      begin
         if (tbl_type[sel] == `SPC_DT_TEXT ||
            (is_dw != (tbl_type[sel] == {1'b0, `SPC_DT_I32} || tbl_type[sel] == {1'b0, `SPC_DT_U32})))
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_TYPE};
         end
         else if (!tbl_wr_ok[sel])
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_NOWR};
         end
         else if (ctrl_r[1])
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_FACT};
         end
         else if (tbl_stop_only[sel] && ctrl_r[0])
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_MODE};
         end
         else if (wval > tbl_max[sel])
         begin
            err = 1'b1;
            rval = {24'h000000, `SPC_ERR_LIMIT};
         end
         else
         begin
            do_wr = 1'b1;
            rval = wval;
            rcode = is_dw ? `SPC_RPL_DWORD : `SPC_RPL_WORD;
         end
      end
      else
      begin
         err = 1'b1;
         rval = {24'h000000, `SPC_ERR_TYPE};
      end
      if (err)
      begin
         rcode = `SPC_RPL_ERR;
      end
      status_nxt = status_r;
      if (rd_in && addr_in == `SPC_ADR_STATUS)
      begin
         status_nxt = 2'b00;
      end
      // New events are or-ed in after the read clear so that they are never lost.
      if (go_r)
      begin
         status_nxt = status_nxt | {err, 1'b1};
      end
   end

   // Register port, request execution and reply latch.
   always @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ident_r <= 16'h0000;
         index_r <= 16'h0000;
         val_hi_r <= 16'h0000;
         val_lo_r <= 16'h0000;
         r_ident_r <= 16'h0000;
         r_index_r <= 16'h0000;
         r_val_r <= 32'h00000000;
         status_r <= 2'b00;
         mask_r <= 2'b00;
         ctrl_r <= `SPC_CTRL_RST;
         go_r <= 1'b0;
         rdata_out <= 16'h0000;
         irq_out <= 1'b0;
         telegram_length_byte_out <= 8'h00;
         for (j = 0; j < NUM_PARAMS; j = j + 1)
         begin
            val_r[j] <= 32'h00000000;
         end
         for (j = 0; j < ARRAY_LEN; j = j + 1)
         begin
            arr_r[j] <= 32'h00000000;
         end
      end
      else
      begin
         go_r <= wr_in && addr_in == `SPC_ADR_GO;
         if (wr_in)
         begin
            case (addr_in)
               `SPC_ADR_IDENT: ident_r <= wdata_in;
               `SPC_ADR_INDEX: index_r <= wdata_in;
               `SPC_ADR_VAL_HI: val_hi_r <= wdata_in;
               `SPC_ADR_VAL_LO: val_lo_r <= wdata_in;
               `SPC_ADR_IRQ_MASK: mask_r <= wdata_in[1:0];
               `SPC_ADR_CTRL: ctrl_r <= wdata_in[3:0];
               default: ;
            endcase
         end
         if (go_r)
         begin
            // The reply keeps number and index; in the identifier only the code field changes.
            r_ident_r <= {rcode, ident_r[11:0]};
            r_index_r <= index_r;
            r_val_r <= rval;
            telegram_length_byte_out <= len_nxt;
            if (do_wr && tbl_is_arr[sel])
            begin
               arr_r[idx[1:0]] <= wval;
            end
            else if (do_wr)
            begin
               val_r[sel] <= wval;
            end
         end
         status_r <= status_nxt;
         irq_out <= |(status_nxt & mask_r);
         rdata_out <= 16'h0000;
         if (rd_in)
         begin
            case (addr_in)
               `SPC_ADR_IDENT: rdata_out <= ident_r;
               `SPC_ADR_INDEX: rdata_out <= index_r;
               `SPC_ADR_VAL_HI: rdata_out <= val_hi_r;
               `SPC_ADR_VAL_LO: rdata_out <= val_lo_r;
               `SPC_ADR_R_IDENT: rdata_out <= r_ident_r;
               `SPC_ADR_R_INDEX: rdata_out <= r_index_r;
               `SPC_ADR_R_VAL_HI: rdata_out <= r_val_r[31:16];
               `SPC_ADR_R_VAL_LO: rdata_out <= r_val_r[15:0];
               `SPC_ADR_STATUS: rdata_out <= {14'h0000, status_r};
               `SPC_ADR_IRQ_MASK: rdata_out <= {14'h0000, mask_r};
               `SPC_ADR_CTRL: rdata_out <= {12'h000, ctrl_r};
               `SPC_ADR_TEXT_LEN: rdata_out <= {8'h00, telegram_length_byte_out};
               default: rdata_out <= 16'h0000;
            endcase
         end
      end
   end
endmodule // spc_channel

// [tb/spc_channel_monitor.sv]
// Purpose: Port checker for the parameter channel.
// Assumes: One clock, asynchronous active-low reset.
// Notes: The mask is shadowed from bus writes because only the ports are visible.
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_channel_monitor #(
   parameter TEXT_LEN = 8'h08
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic irq_out,
   input wire logic [7:0] telegram_length_byte_out
);
   logic [15:0] mask_r;
   always @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         mask_r <= 16'h0000;
      else if (wr_in && addr_in == `SPC_ADR_IRQ_MASK)
         mask_r <= {14'h0000, wdata_in[1:0]};
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 16'h0000)
      else $error("read data outside its slot");
   AST_RD_UNMAPPED: assert property (rd_in && addr_in > `SPC_ADR_TEXT_LEN |=> rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   AST_LEN_VALUES: assert property (telegram_length_byte_out == 8'h00 || telegram_length_byte_out == 8'h0E
      || telegram_length_byte_out == 8'h0A + TEXT_LEN) else $error("bad telegram length");
   AST_LEN_MOVE: assert property (!$stable(telegram_length_byte_out) |-> $past(wr_in) || $past(wr_in, 2)
      || $past(wr_in, 3)) else $error("length changed without request");
   AST_IRQ_MASK: assert property (irq_out |-> mask_r != 16'h0000 || $past(mask_r) != 16'h0000)
      else $error("interrupt with empty mask");
   AST_IRQ_RISE: assert property ($rose(irq_out) |-> $past(wr_in) || $past(wr_in, 2) || $past(wr_in, 3))
      else $error("interrupt rose without a request");
   AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(rd_in) || $past(rd_in, 2) || $past(wr_in)
      || $past(wr_in, 2)) else $error("interrupt fell without a read");
   AST_IRQ_CLEAR: assert property (rd_in && addr_in == `SPC_ADR_STATUS && !$past(wr_in) && !$past(wr_in, 2)
      |=> ##1 !irq_out) else $error("status read left interrupt high");
   AST_RST_QUIET: assert property ($rose(rst_n_in) |-> !irq_out && rdata_out == 16'h0000
      && telegram_length_byte_out == 8'h00) else $error("outputs not quiet after reset");
   cover property ($rose(irq_out));
   cover property (telegram_length_byte_out == 8'h0A + TEXT_LEN);
   cover property (rd_in && addr_in == `SPC_ADR_STATUS);
endmodule // spc_channel_monitor
bind spc_channel spc_channel_monitor #(.TEXT_LEN(TEXT_LEN)) u_mon (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .irq_out(irq_out), .telegram_length_byte_out(telegram_length_byte_out));

// [tb/spc_bus_master.sv]
// Purpose: Master on the register port, the party that sends requests.
// Assumes: Strobes are one cycle long; read data stand in the cycle after the strobe.
// Notes: Write data are inverted when released so stale values never look valid.
`timescale 1ns/1ps
module spc_bus_master (
   input wire logic clk_sys_in,
   input wire logic [15:0] rdata_out,
   output logic [3:0] addr_in,
   output logic [15:0] wdata_in,
   output logic wr_in,
   output logic rd_in
);
   initial
   begin
      addr_in = 4'h0;
      wdata_in = 16'h0000;
      wr_in = 1'b0;
      rd_in = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
      wdata_in <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
endmodule // spc_bus_master

// [tb/tb_serial_parameter_channel.sv]
// Purpose: Self-checking bench for the parameter channel.
// Assumes: Reply registers are valid two edges after the go write.
// Notes: Table numbers start at 0x64, entry 0 is an array, entry 1 a text; text length is the default eight.
`timescale 1ns/1ps
`include "spc_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_serial_parameter_channel;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] addr_in;
   logic [15:0] wdata_in, rdata_out, d;
   logic wr_in, rd_in, irq_out;
   logic [7:0] telegram_length_byte_out;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   spc_channel dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
      .telegram_length_byte_out(telegram_length_byte_out));
   spc_bus_master m (.clk_sys_in(clk_sys_in), .rdata_out(rdata_out), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in));
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         stop_test;
      end
   end
   // Sends one request and checks the echoed identifier and index.
   task automatic req(input logic [15:0] id, ix, hi, lo, input logic [3:0] code);
      m.wr(`SPC_ADR_IDENT, id);
      m.wr(`SPC_ADR_INDEX, ix);
      m.wr(`SPC_ADR_VAL_HI, hi);
      m.wr(`SPC_ADR_VAL_LO, lo);
      m.wr(`SPC_ADR_GO, 16'h0001);
      repeat (2) @(posedge clk_sys_in);
      m.rd(`SPC_ADR_R_IDENT, d);
      `CHK(d, {code, id[11:0]})
      m.rd(`SPC_ADR_R_INDEX, d);
      `CHK(d, ix)
   endtask
   task automatic val(input logic [15:0] hi, lo);
      m.rd(`SPC_ADR_R_VAL_HI, d);
      `CHK(d, hi)
      m.rd(`SPC_ADR_R_VAL_LO, d);
      `CHK(d, lo)
   endtask
   task automatic t_write_read;
      req(16'h2066, 16'h0000, 16'h0000, 16'h0014, `SPC_RPL_WORD);
      req(16'h1066, 16'h0000, 16'h0000, 16'h0000, `SPC_RPL_WORD);
      val(16'h0000, 16'h0014);
      `CHK(telegram_length_byte_out, 8'h0E)
   endtask
   task automatic t_limit;
      req(16'h2066, 16'h0000, 16'h0000, 16'h03E9, `SPC_RPL_ERR);
      val(16'h0000, {8'h00, `SPC_ERR_LIMIT});
      req(16'h1066, 16'h0000, 16'h0000, 16'h0000, `SPC_RPL_WORD);
      val(16'h0000, 16'h0014);
   endtask
   task automatic t_errors;
      logic [15:0] ids [8] = '{16'h1070, 16'h2067, 16'h1064, 16'h1066, 16'h3066, 16'h1069, 16'h3068, 16'h2066};
      logic [15:0] ixs [8] = '{16'h0000, 16'h0000, 16'h0005, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      logic [15:0] ctl [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0002};
      logic [7:0] ers [8] = '{`SPC_ERR_PNU, `SPC_ERR_NOWR, `SPC_ERR_SUBIDX, `SPC_ERR_NOTARR, `SPC_ERR_TYPE,
         `SPC_ERR_NOBUS, `SPC_ERR_MODE, `SPC_ERR_FACT};
      for (int i = 0; i < 8; i++)
      begin
         m.wr(`SPC_ADR_CTRL, ctl[i]);
         req(ids[i], ixs[i], 16'h0000, 16'h0000, `SPC_RPL_ERR);
         val(16'h0000, {8'h00, ers[i]});
      end
      m.wr(`SPC_ADR_CTRL, 16'h0000);
   endtask
   task automatic t_text;
      req(16'hF065, 16'h0000, 16'h0000, 16'h0000, `SPC_RPL_TEXT);
      `CHK(telegram_length_byte_out, 8'h12)
      req(16'hF065, 16'h0001, 16'h0000, 16'h0041, `SPC_RPL_TEXT);
      req(16'hF065, 16'h0000, 16'h0000, 16'h0000, `SPC_RPL_TEXT);
      val(16'h0000, 16'h0041);
   endtask
   task automatic t_irq;
      m.rd(`SPC_ADR_STATUS, d);
      `CHK(irq_out, 1'b0)
      m.wr(`SPC_ADR_IRQ_MASK, 16'h0001);
      req(16'h1066, 16'h0000, 16'h0000, 16'h0000, `SPC_RPL_WORD);
      `CHK(irq_out, 1'b1)
      m.rd(`SPC_ADR_STATUS, d);
      `CHK(d, 16'h0001)
      @(posedge clk_sys_in);
      #1 `CHK(irq_out, 1'b0)
      m.rd(4'hD, d);
      `CHK(d, 16'h0000)
      req(16'h1070, 16'h0000, 16'h0000, 16'h0000, `SPC_RPL_ERR);
      m.rd(`SPC_ADR_STATUS, d);
      `CHK(d, 16'h0003)
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      #1 `CHK(rdata_out, 16'h0000)
      t_write_read;
      t_limit;
      t_errors;
      t_text;
      t_irq;
      stop_test;
   end
endmodule // tb_serial_parameter_channel
